// >>> hdl/cebr_fifo.sv
/*
 * Request FIFO of flip-flops with valid and ready on both sides.
 * Assumes both sides run on ref_clk; the drain side may stall freely.
 */
`timescale 1ns/100ps
module cebr_fifo #(
	parameter int WIDTH = 69,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0]   CNT_FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0]      cnt_r, cnt_nxt;
	logic             push, pop;
	logic             in_rdy_r, in_rdy_nxt;

	// Pointer and count bookkeeping; full and empty follow the count.
	always_comb begin
		push    = in_valid && (cnt_r != CNT_FULL);
		pop     = out_ready && (cnt_r != '0);
		wr_nxt  = push ? ((wr_r == PTR_LAST) ? '0 : PW'(wr_r + 1'b1)) : wr_r;
		rd_nxt  = pop ? ((rd_r == PTR_LAST) ? '0 : PW'(rd_r + 1'b1)) : rd_r;
		cnt_nxt = (PW+1)'(cnt_r + {PW'(0), push} - {PW'(0), pop});
		in_rdy_nxt = (cnt_nxt != CNT_FULL);
	end

	// Registers the pointers; ready is a flop so the user sees a clean level.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_r     <= '0;
			rd_r     <= '0;
			cnt_r    <= '0;
			in_rdy_r <= 1'b1;
		end else begin
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			cnt_r    <= cnt_nxt;
			in_rdy_r <= in_rdy_nxt;
		end
	end

	// Writes the addressed entry; storage needs no reset.
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	assign in_ready  = in_rdy_r;
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
endmodule // cebr_fifo

// >>> hdl/cebr_pkg.sv
/*
 * Constants, field layouts and types for the core external bus request unit.
 * Assumes one 20 MHz core clock and a target built from logic on that clock.
 */
// Contract
// - Two-bit static input selects write-buffer merge policy.
// - Address phase ends only on sampled accept.
// - Request valid marks new transaction, always defined.
// - Fetch flag high for instruction fetches.
// - Store flag high for writes only.
// - Line flag agrees with first, final, length.
// - Line first flag driven valid every cycle.
// - Line final flag driven valid every cycle.
// - Length code always one, meaning four beats.
// - Order select chooses sub-block or linear order.
// - Lane enable n qualifies byte lane n.
package cebr_pkg;

	// Merge policy encodings of the static select.
	localparam logic [1:0] MERGE_NONE     = 2'h0;
	localparam logic [1:0] MERGE_BUSVALID = 2'h1;
	localparam logic [1:0] MERGE_FULL     = 2'h2;
	localparam logic [1:0] MERGE_RSVD     = 2'h3;

	// Burst framing constants.
	localparam logic [1:0] LINE_LEN_CODE  = 2'h1;
	localparam logic [1:0] BEAT_FIRST     = 2'h0;
	localparam logic [1:0] BEAT_LAST      = 2'h3;
	localparam logic [3:0] LANES_ALL      = 4'hf;
	localparam logic [3:0] LANES_NONE     = 4'h0;

	// Widths of the request path.
	localparam int ADDR_W     = 30;
	localparam int BLOCK_W    = 28;
	localparam int DATA_W     = 32;
	localparam int BYTE_W     = 8;
	localparam int LANE_N     = 4;
	localparam int WORDS_N    = 4;
	localparam int FIFO_DEPTH = 4;

	// Packed request word layout: fetch, store, line, lanes, word address, data.
	localparam int REQ_DATA_LO  = 0;
	localparam int REQ_ADDR_LO  = 32;
	localparam int REQ_LANE_LO  = 62;
	localparam int REQ_LINE_BIT = 66;
	localparam int REQ_STORE_BIT = 67;
	localparam int REQ_FETCH_BIT = 68;
	localparam int REQ_W        = 69;

	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_FLUSH} cebr_state_type;

	// Word of a line for a given beat: sub-block order XORs, linear order wraps.
	function automatic logic [1:0] cebr_beat_word(input logic [1:0] base,
		input logic [1:0] beat, input logic sub_block);
		cebr_beat_word = sub_block ? (base ^ beat) : 2'(base + beat);
	endfunction

endpackage

// >>> hdl/cebr_request_unit.sv
/*
 * Request side of the core external bus: FIFO, collapsing write buffer and
 * address-phase engine with line bursts. Assumes the target runs on ref_clk;
 * merge and order selects are static pins and are synchronised.
 */
`timescale 1ns/100ps
module cebr_request_unit
	import cebr_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_fetch,
	input  wire logic              req_store,
	input  wire logic              req_line,
	input  wire logic [LANE_N-1:0] req_lanes,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_word,
	input  wire logic [1:0]        write_buffer_merge_select,
	input  wire logic              line_order_select,
	input  wire logic              target_addr_accept,
	input  wire logic              target_read_valid,
	input  wire logic [DATA_W-1:0] bus_read_word,
	output logic                   bus_request_valid,
	output logic      [ADDR_W-1:0] bus_word_addr,
	output logic                   bus_fetch_flag,
	output logic                   bus_store_flag,
	output logic                   bus_line_transfer_flag,
	output logic                   bus_line_first,
	output logic                   bus_line_final,
	output logic      [1:0]        bus_line_length_code,
	output logic      [LANE_N-1:0] bus_lane_enables,
	output logic      [DATA_W-1:0] bus_write_word
);
	logic             in_ready;
	logic             head_valid, pop;
	logic [REQ_W-1:0] head;
	logic [1:0]       merge_s1_r, merge_s2_r;
	logic             order_s1_r, order_s2_r;

	// Request FIFO; its ready is the user-side back-pressure.
	cebr_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) cebr_fifo_inst (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (req_valid),
		.in_ready  (in_ready),
		.in_data   ({req_fetch, req_store, req_line, req_lanes, req_addr, req_wdata}),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head)
	);

	// Static selects pass two flip-flops before use.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			merge_s1_r <= MERGE_NONE;
			merge_s2_r <= MERGE_NONE;
			order_s1_r <= 1'b0;
			order_s2_r <= 1'b0;
		end else begin
			merge_s1_r <= write_buffer_merge_select;
			merge_s2_r <= merge_s1_r;
			order_s1_r <= line_order_select;
			order_s2_r <= order_s1_r;
		end
	end

	// Head fields.
	logic              h_fetch, h_store, h_line;
	logic [LANE_N-1:0] h_lanes;
	logic [ADDR_W-1:0] h_addr;
	logic [DATA_W-1:0] h_data;
	assign h_fetch = head[REQ_FETCH_BIT];
	assign h_store = head[REQ_STORE_BIT];
	assign h_line  = head[REQ_LINE_BIT];
	assign h_lanes = head[REQ_LANE_LO +: LANE_N];
	assign h_addr  = head[REQ_ADDR_LO +: ADDR_W];
	assign h_data  = head[REQ_DATA_LO +: DATA_W];

	// Engine, write buffer and bus output state.
	cebr_state_type    st_r, st_nxt;
	logic [1:0]        beat_r, beat_nxt, fl_idx_r, fl_idx_nxt, cur_idx_r, cur_idx_nxt;
	logic [BLOCK_W-1:0] cur_blk_r, cur_blk_nxt, lb_blk_r, lb_blk_nxt;
	logic              cur_fetch_r, cur_fetch_nxt, cur_store_r, cur_store_nxt;
	logic              cur_line_r, cur_line_nxt, lb_valid_r, lb_valid_nxt;
	logic [LANE_N-1:0] cur_lanes_r, cur_lanes_nxt;
	logic [LANE_N-1:0] lb_lanes_r [WORDS_N];
	logic [LANE_N-1:0] lb_lanes_nxt [WORDS_N];
	logic [DATA_W-1:0] lb_word_r [WORDS_N];
	logic [DATA_W-1:0] lb_word_nxt [WORDS_N];
	logic              av_r, av_nxt, fe_r, fe_nxt, sto_r, sto_nxt, ln_r, ln_nxt;
	logic              fi_r, fi_nxt, la_r, la_nxt;
	logic [ADDR_W-1:0] ad_r, ad_nxt;
	logic [LANE_N-1:0] be_r, be_nxt;
	logic [DATA_W-1:0] wd_r, wd_nxt;
	logic              rv_r, rv_nxt;
	logic [DATA_W-1:0] rw_r, rw_nxt;
	logic [1:0]        len_r;

	// Whether a store at the head may collapse into the held block.
	function automatic logic merge_ok(input logic [1:0] mode, input logic same_blk,
		input logic word_held);
		merge_ok = same_blk && ((mode == MERGE_FULL) || ((mode == MERGE_BUSVALID) && word_held));
	endfunction

	// Next state of engine, write buffer and bus outputs.
	always_comb begin
		logic full_line;
		logic [1:0] w;
		full_line = 1'b1;
		w = 2'h0;
		for (int i = 0; i < WORDS_N; i++) begin
			full_line = full_line && (lb_lanes_r[i] == LANES_ALL);
		end
		full_line = full_line && (merge_s2_r == MERGE_FULL);
		st_nxt = st_r;
		beat_nxt = beat_r;
		fl_idx_nxt = fl_idx_r;
		cur_idx_nxt = cur_idx_r;
		cur_blk_nxt = cur_blk_r;
		cur_fetch_nxt = cur_fetch_r;
		cur_store_nxt = cur_store_r;
		cur_line_nxt = cur_line_r;
		cur_lanes_nxt = cur_lanes_r;
		lb_valid_nxt = lb_valid_r;
		lb_blk_nxt = lb_blk_r;
		lb_lanes_nxt = lb_lanes_r;
		lb_word_nxt = lb_word_r;
		pop = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (head_valid && h_store && lb_valid_r &&
					merge_ok(merge_s2_r, h_addr[ADDR_W-1:2] == lb_blk_r,
					lb_lanes_r[h_addr[1:0]] != LANES_NONE)) begin
					// Collapse the store bytes into the held word.
					pop = 1'b1;
					for (int b = 0; b < LANE_N; b++) begin
						if (h_lanes[b]) begin
							lb_word_nxt[h_addr[1:0]][BYTE_W*b +: BYTE_W] = h_data[BYTE_W*b +: BYTE_W];
						end
					end
					lb_lanes_nxt[h_addr[1:0]] = lb_lanes_r[h_addr[1:0]] | h_lanes;
				end else if (lb_valid_r) begin
					// Drain the buffer: one line burst, or word by word.
					cur_blk_nxt = lb_blk_r;
					cur_store_nxt = 1'b1;
					cur_fetch_nxt = 1'b0;
					beat_nxt = BEAT_FIRST;
					fl_idx_nxt = BEAT_FIRST;
					if (full_line) begin
						cur_line_nxt = 1'b1;
						cur_idx_nxt = BEAT_FIRST;
						st_nxt = ST_ADDR;
					end else begin
						st_nxt = ST_FLUSH;
					end
				end else if (head_valid && h_store) begin
					pop = 1'b1;
					lb_valid_nxt = 1'b1;
					lb_blk_nxt = h_addr[ADDR_W-1:2];
					for (int i = 0; i < WORDS_N; i++) begin
						lb_lanes_nxt[i] = (h_addr[1:0] == 2'(i)) ? h_lanes : LANES_NONE;
						lb_word_nxt[i] = h_data;
					end
				end else if (head_valid) begin
					pop = 1'b1;
					cur_blk_nxt = h_addr[ADDR_W-1:2];
					cur_idx_nxt = h_addr[1:0];
					cur_fetch_nxt = h_fetch;
					cur_store_nxt = 1'b0;
					cur_line_nxt = h_line;
					cur_lanes_nxt = h_line ? LANES_ALL : h_lanes;
					beat_nxt = BEAT_FIRST;
					st_nxt = ST_ADDR;
				end
			end
			ST_FLUSH: begin
				if (lb_lanes_r[fl_idx_r] != LANES_NONE) begin
					cur_line_nxt = 1'b0;
					cur_idx_nxt = fl_idx_r;
					beat_nxt = BEAT_FIRST;
					st_nxt = ST_ADDR;
				end else if (fl_idx_r == BEAT_LAST) begin
					lb_valid_nxt = 1'b0;
					st_nxt = ST_IDLE;
				end else begin
					fl_idx_nxt = 2'(fl_idx_r + 1'b1);
				end
			end
			ST_ADDR: begin
				if (target_addr_accept) begin
					if (cur_line_r && (beat_r != BEAT_LAST)) begin
						beat_nxt = 2'(beat_r + 1'b1);
					end else if (cur_store_r && cur_line_r) begin
						lb_valid_nxt = 1'b0;
						for (int i = 0; i < WORDS_N; i++) begin
							lb_lanes_nxt[i] = LANES_NONE;
						end
						st_nxt = ST_IDLE;
					end else if (cur_store_r) begin
						lb_lanes_nxt[cur_idx_r] = LANES_NONE;
						st_nxt = ST_FLUSH;
					end else begin
						st_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		// Bus outputs follow the next state; idle levels are all low.
		w = cebr_beat_word(cur_idx_nxt, beat_nxt, order_s2_r);
		av_nxt = (st_nxt == ST_ADDR);
		ad_nxt = av_nxt ? {cur_blk_nxt, w} : '0;
		fe_nxt = av_nxt && cur_fetch_nxt;
		sto_nxt = av_nxt && cur_store_nxt;
		ln_nxt = av_nxt && cur_line_nxt;
		fi_nxt = ln_nxt && (beat_nxt == BEAT_FIRST);
		la_nxt = ln_nxt && (beat_nxt == BEAT_LAST);
		be_nxt = !av_nxt ? LANES_NONE : cur_store_nxt ? lb_lanes_nxt[w] : cur_lanes_nxt;
		wd_nxt = sto_nxt ? lb_word_nxt[w] : '0;
		rv_nxt = target_read_valid;
		rw_nxt = target_read_valid ? bus_read_word : '0;
	end

	// Registers all engine and output state.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			beat_r <= BEAT_FIRST;
			fl_idx_r <= BEAT_FIRST;
			cur_idx_r <= BEAT_FIRST;
			cur_blk_r <= '0;
			cur_fetch_r <= 1'b0;
			cur_store_r <= 1'b0;
			cur_line_r <= 1'b0;
			cur_lanes_r <= LANES_NONE;
			lb_valid_r <= 1'b0;
			lb_blk_r <= '0;
			for (int i = 0; i < WORDS_N; i++) begin
				lb_lanes_r[i] <= LANES_NONE;
				lb_word_r[i] <= '0;
			end
			{av_r, fe_r, sto_r, ln_r, fi_r, la_r, rv_r} <= '0;
			ad_r <= '0;
			be_r <= LANES_NONE;
			wd_r <= '0;
			rw_r <= '0;
			len_r <= LINE_LEN_CODE;
		end else begin
			st_r <= st_nxt;
			beat_r <= beat_nxt;
			fl_idx_r <= fl_idx_nxt;
			cur_idx_r <= cur_idx_nxt;
			cur_blk_r <= cur_blk_nxt;
			cur_fetch_r <= cur_fetch_nxt;
			cur_store_r <= cur_store_nxt;
			cur_line_r <= cur_line_nxt;
			cur_lanes_r <= cur_lanes_nxt;
			lb_valid_r <= lb_valid_nxt;
			lb_blk_r <= lb_blk_nxt;
			lb_lanes_r <= lb_lanes_nxt;
			lb_word_r <= lb_word_nxt;
			{av_r, fe_r, sto_r, ln_r, fi_r, la_r, rv_r} <=
				{av_nxt, fe_nxt, sto_nxt, ln_nxt, fi_nxt, la_nxt, rv_nxt};
			ad_r <= ad_nxt;
			be_r <= be_nxt;
			wd_r <= wd_nxt;
			rw_r <= rw_nxt;
			len_r <= LINE_LEN_CODE;
		end
	end

	// Outputs come from the registers above, req_ready from the FIFO ready flop; the length code is a constant.
	assign req_ready = in_ready;
	assign rsp_valid = rv_r;
	assign rsp_word = rw_r;
	assign bus_request_valid = av_r;
	assign bus_word_addr = ad_r;
	assign bus_fetch_flag = fe_r;
	assign bus_store_flag = sto_r;
	assign bus_line_transfer_flag = ln_r;
	assign bus_line_first = fi_r;
	assign bus_line_final = la_r;
	assign bus_line_length_code = len_r;
	assign bus_lane_enables = be_r;
	assign bus_write_word = wd_r;
endmodule // cebr_request_unit

// >>> tb/cebr_request_unit_bench.sv
/* Self-checking bench for the request unit with a behavioural target.
 * Assumes the checker is bound by its own file. */
`timescale 1ns/100ps
module cebr_request_unit_bench
	import cebr_pkg::*;
;
	logic              ref_clk, rstn, req_valid, req_ready, req_fetch, req_store, req_line;
	logic              rsp_valid, line_order_select, target_addr_accept, target_read_valid;
	logic              bus_request_valid, bus_fetch_flag, bus_store_flag, bus_line_transfer_flag;
	logic              bus_line_first, bus_line_final;
	logic              full_seen = 1'b0;
	logic [1:0]        write_buffer_merge_select, bus_line_length_code, slow_cycles;
	logic [LANE_N-1:0] req_lanes, bus_lane_enables;
	logic [ADDR_W-1:0] req_addr, bus_word_addr, aq[$];
	logic [DATA_W-1:0] req_wdata, rsp_word, bus_read_word, bus_write_word, dq[$], rq[$];
	logic [8:0]        fq[$];
	int                mismatches = 0;
	int                cmp_count = 0;

	cebr_request_unit cebr_request_unit_inst (.*);
	cebr_target_model cebr_target_model_inst (.*);

	// Clock of 50 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Log accepted address phases, read answers and a full FIFO.
	always @(posedge ref_clk) begin
		if (bus_request_valid && target_addr_accept) begin
			aq.push_back(bus_word_addr);
			fq.push_back({bus_fetch_flag, bus_store_flag, bus_line_transfer_flag,
				bus_line_first, bus_line_final, bus_lane_enables});
			dq.push_back(bus_write_word);
		end
		if (rsp_valid)
			rq.push_back(rsp_word);
		if (rstn && !req_ready)
			full_seen = 1'b1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic push(input logic [2:0] kind, input logic [3:0] lanes,
		input logic [29:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{req_fetch, req_store, req_line} = kind;
		req_lanes = lanes;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		// Ready moves only on rising edges, so the level seen here is what the next edge samples.
		while (!req_ready && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 100)
			mismatches++;
		@(negedge ref_clk);
	endtask

	task automatic idle();
		req_valid = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask

	task automatic expect_phase(input logic [29:0] a, input logic [8:0] f,
		input logic [31:0] d);
		repeat (200) if (aq.size() == 0) @(posedge ref_clk);
		chk(aq.size() ? 32'(aq.pop_front()) : 32'hx, 32'(a));
		chk(fq.size() ? 32'(fq.pop_front()) : 32'hx, 32'(f));
		chk(dq.size() ? dq.pop_front() : 32'hx, d);
		if (!f[7]) begin
			repeat (20) if (rq.size() == 0) @(posedge ref_clk);
			chk(rq.size() ? rq.pop_front() : 32'hx, {a, 2'h0});
		end
	endtask

	task automatic t_reads();
		@(negedge ref_clk);
		slow_cycles = 2'h3;
		for (int i = 0; i < 6; i++)
			push({i[0], 2'h0}, 4'h1 << (i % 4), 30'h100 + 30'(i), 32'h0);
		idle();
		chk(32'(full_seen), 32'h1);
		for (int i = 0; i < 6; i++)
			expect_phase(30'h100 + 30'(i), {i[0], 4'h0, 4'h1 << (i % 4)}, 32'h0);
		$display("Test reads done");
	endtask

	task automatic t_lines();
		for (int o = 0; o < 2; o++) begin
			@(negedge ref_clk);
			slow_cycles = 2'h0;
			line_order_select = o[0];
			repeat (4) @(negedge ref_clk);
			push(3'h5, 4'hf, 30'h201, 32'h0);
			idle();
			for (int b = 0; b < 4; b++)
				expect_phase(30'h200 | 30'(o ? (1 ^ b) : ((1 + b) & 3)),
					{2'h2, 1'b1, b == 0, b == 3, 4'hf}, 32'h0);
		end
		$display("Test lines done");
	endtask

	task automatic t_stores();
		for (int m = 0; m < 4; m++) begin
			@(negedge ref_clk);
			write_buffer_merge_select = 2'(m);
			slow_cycles = 2'h1;
			repeat (4) @(negedge ref_clk);
			if (m == 2) begin
				for (int w = 0; w < 4; w++)
					push(3'h2, 4'hf, 30'h300 + 30'(w), 32'h11111111 * 32'(w + 1));
				idle();
				for (int w = 0; w < 4; w++)
					expect_phase(30'h300 + 30'(w), {3'h3, w == 0, w == 3, 4'hf},
						32'h11111111 * 32'(w + 1));
			end else begin
				if (m == 1) begin
					// A second store into a word that already holds bytes collapses.
					push(3'h2, 4'h3, 30'h300, 32'h0000a55a);
					push(3'h2, 4'hc, 30'h300, 32'h3cc30000);
					idle();
					expect_phase(30'h300, {5'h08, 4'hf}, 32'h3cc3a55a);
					@(negedge ref_clk);
				end
				push(3'h2, 4'h3, 30'h300, 32'h0000a55a);
				push(3'h2, 4'hc, 30'h301, 32'h3cc30000);
				idle();
				expect_phase(30'h300, {5'h08, 4'h3}, 32'h0000a55a);
				expect_phase(30'h301, {5'h08, 4'hc}, 32'h3cc30000);
			end
		end
		$display("Test stores done");
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reset, then run the scenarios.
	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		{req_fetch, req_store, req_line} = 3'h0;
		req_lanes = 4'h0;
		req_addr = 30'h0;
		req_wdata = 32'h0;
		write_buffer_merge_select = 2'h0;
		line_order_select = 1'b0;
		slow_cycles = 2'h0;
		repeat (4) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_reads();
		t_lines();
		t_stores();
		finish_test();
	end

	// Cut a hang short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		finish_test();
	end
endmodule // cebr_request_unit_bench

// >>> tb/cebr_request_unit_sva.sv
/* Checker for the bus side of the request unit.
 * Assumes it is bound to cebr_request_unit and sees only its ports. */
`timescale 1ns/100ps
module cebr_request_unit_sva
	import cebr_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rstn,
	input wire logic              target_addr_accept,
	input wire logic              target_read_valid,
	input wire logic [DATA_W-1:0] bus_read_word,
	input wire logic              rsp_valid,
	input wire logic [DATA_W-1:0] rsp_word,
	input wire logic              bus_request_valid,
	input wire logic [ADDR_W-1:0] bus_word_addr,
	input wire logic              bus_fetch_flag,
	input wire logic              bus_store_flag,
	input wire logic              bus_line_transfer_flag,
	input wire logic              bus_line_first,
	input wire logic              bus_line_final,
	input wire logic [1:0]        bus_line_length_code,
	input wire logic [LANE_N-1:0] bus_lane_enables,
	input wire logic [DATA_W-1:0] bus_write_word
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// A first line beat taken by the target.
	sequence line_start_s;
		bus_request_valid && bus_line_first && target_addr_accept;
	endsequence

	// Request checks.
	hold_until_accept_a: assert property (
		bus_request_valid && !target_addr_accept |=> bus_request_valid && $stable(bus_word_addr))
		else $error("Request dropped before accept.");
	len_code_a: assert property (bus_line_length_code == LINE_LEN_CODE)
		else $error("Bad length code.");
	idle_flags_a: assert property (
		!bus_request_valid |-> !bus_line_first && !bus_line_final && !bus_line_transfer_flag)
		else $error("Framing flag while idle.");
	line_flag_a: assert property (
		bus_request_valid && (bus_line_first || bus_line_final) |-> bus_line_transfer_flag)
		else $error("Framing without line flag.");
	line_beat_a: assert property (
		line_start_s |-> !bus_line_final ##1 bus_request_valid && !bus_line_first)
		else $error("Line beat sequence broken.");
	line_lanes_a: assert property (
		bus_request_valid && bus_line_transfer_flag && !bus_store_flag
		|-> bus_lane_enables == LANES_ALL) else $error("Line read lanes wrong.");
	read_data_a: assert property (
		bus_request_valid && !bus_store_flag |-> bus_write_word == 32'h0)
		else $error("Write data on a read.");
	fetch_store_a: assert property (
		bus_request_valid && bus_store_flag |-> !bus_fetch_flag)
		else $error("Fetch flag on a store.");
	rsp_delay_a: assert property (
		target_read_valid |=> rsp_valid && rsp_word == $past(bus_read_word))
		else $error("Read answer wrong.");

	// The last line beat taken by the target.
	sequence line_end_s;
		bus_request_valid && bus_line_final && target_addr_accept;
	endsequence

	line_end_a: assert property (line_end_s |=> !bus_request_valid)
		else $error("Request held after last beat.");
endmodule // cebr_request_unit_sva

bind cebr_request_unit cebr_request_unit_sva cebr_request_unit_sva_inst (.*);

// >>> tb/cebr_target_model.sv
/* Behavioural bus target facing the request unit.
 * Assumes ref_clk and rstn are shared; slow_cycles sets waits before accept. */
`timescale 1ns/100ps
module cebr_target_model
	import cebr_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic [1:0]        slow_cycles,
	input  wire logic              bus_request_valid,
	input  wire logic              bus_store_flag,
	input  wire logic [ADDR_W-1:0] bus_word_addr,
	output logic                   target_addr_accept,
	output logic                   target_read_valid,
	output logic      [DATA_W-1:0] bus_read_word
);
	logic [1:0] wait_r;

	// Count waits; answer a read one edge after its accept, else scramble data.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_r            <= 2'h0;
			target_read_valid <= 1'b0;
			bus_read_word     <= 32'h0;
		end else begin
			wait_r <= (bus_request_valid && !target_addr_accept) ? wait_r + 2'h1 : 2'h0;
			target_read_valid <= target_addr_accept && !bus_store_flag;
			bus_read_word <= (target_addr_accept && !bus_store_flag) ?
				{bus_word_addr, 2'h0} : ~bus_read_word;
		end
	end

	// Accept once the chosen number of wait cycles has passed.
	assign target_addr_accept = bus_request_valid && wait_r >= slow_cycles;
endmodule // cebr_target_model
